// file: logic/lcfo_map.svh
// Register offsets, field positions and reset values of the frame options
`ifndef LCFO_MAP_SVH
`define LCFO_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LCFO_OFF_CTRL      8'h00
`define LCFO_OFF_BAUD      8'h04
`define LCFO_OFF_STATUS    8'h08
`define LCFO_OFF_RXDATA    8'h0c
`define LCFO_OFF_TXDATA    8'h10
`define LCFO_OFF_CKSUM     8'h14
`define LCFO_OFF_RXBUF     8'h20
`define LCFO_OFF_TXBUF     8'h40
`define LCFO_BUF_SPAN      8'h20

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define LCFO_CTRL_CKS      11
`define LCFO_CTRL_MBUF     10
`define LCFO_CTRL_ADAPT    9
`define LCFO_CTRL_LIN      6
`define LCFO_CTRL_SLAVE    5

// ----------------------------------------------------------------------
// Baud fields and status bits
// ----------------------------------------------------------------------
`define LCFO_BAUD_PRESC_LSB 0
`define LCFO_BAUD_PRESC_MSB 23
`define LCFO_BAUD_FRAC_LSB  24
`define LCFO_BAUD_FRAC_MSB  26
`define LCFO_ST_CKS_ERR     0
`define LCFO_ST_BAUD_UPD    1
`define LCFO_ST_MEAS        2
`define LCFO_ST_CNT_LSB     8
`define LCFO_ST_CNT_MSB     11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LCFO_RST_PRESC     24'h000000
`define LCFO_RST_FRAC      3'h0
`define LCFO_RST_BYTE      8'h00

`endif

// file: logic/lcfo_pkg.sv
// Types shared by the frame options block
package lcfo_pkg;

    typedef struct packed {
        logic cks_enh;
        logic mbuf;
        logic adapt;
        logic lin;
        logic slave;
    } lcfo_ctrl_t;

    typedef struct packed {
        logic [2:0]  frac;
        logic [23:0] presc;
    } lcfo_baud_t;

    typedef struct packed {
        logic       valid;
        lcfo_baud_t baud;
    } lcfo_meas_t;

    typedef struct packed {
        logic       id_valid;
        logic       data_valid;
        logic       chk_valid;
        logic [7:0] data;
    } lcfo_rx_t;

    typedef enum logic [1:0] {
        LCFO_IDLE,
        LCFO_SYNC,
        LCFO_WAIT_ID,
        LCFO_DATA
    } lcfo_state_t;

endpackage

// file: logic/lcfo_buf.sv
// Small byte memory with registered read data, used as a multibuffer
`timescale 1ns/10ps
module lcfo_buf #(
    parameter int W = 8,
    parameter int D = 8,
    parameter int A = 3
) (
    input  wire logic         clk,
    input  wire logic         wr_en,
    input  wire logic [A-1:0] wr_addr,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [A-1:0] rd_addr,
    output      logic [W-1:0] rd_data
);
    logic [W-1:0] mem [D];

    // ------------------------------------------------------------------
    // Storage has no reset; only written slots are meaningful
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // lcfo_buf

// file: logic/lcfo_core.sv
// Frame options of a LIN/SCI controller: checksum kind, buffers, baud adapt
//
// How it works
// - Checksum seeds with 0 (classic) or the identifier (enhanced) by bit 11.
// - Multibuffer bit steers data through buffers, else single data registers.
// - Buffer steering applies alike in LIN mode and plain serial mode.
// - Baud auto-adjust acts only in LIN mode during sync field detection.
// - Slave with adjust enabled writes measured prescalers when they differ.
// - Adjust disabled leaves the baud prescaler register untouched.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "lcfo_map.svh"
module lcfo_core import lcfo_pkg::*; #(
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output      logic [31:0]      reg_rdata,
    input  wire logic             sync_detect,
    input  wire lcfo_meas_t       meas,
    input  wire lcfo_rx_t         rx_ev,
    input  wire logic             tx_req,
    input  wire logic [IDX_W-1:0] tx_idx,
    output      logic [7:0]       tx_byte,
    output      logic             tx_byte_valid,
    output      logic [7:0]       tx_cks,
    output      lcfo_baud_t       baud,
    output      lcfo_ctrl_t       ctrl
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_buf(input logic [7:0] a,
                                    input logic [7:0] base);
        return (a >= base) && (a < base + `LCFO_BUF_SPAN)
               && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [IDX_W-1:0] buf_idx(input logic [7:0] a);
        return IDX_W'(a[7:2]);
    endfunction

    // Carry-wrapping byte sum, shared by receive check and transmit
    function automatic logic [7:0] cks_add(input logic [7:0] s,
                                           input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lcfo_state_t      state;
    lcfo_state_t      next_state;
    lcfo_baud_t       next_baud;
    lcfo_ctrl_t       next_ctrl;
    logic [7:0]       sum;
    logic [7:0]       next_sum;
    logic [7:0]       last_cks;
    logic [7:0]       next_last_cks;
    logic             cks_err;
    logic             next_cks_err;
    logic             baud_upd;
    logic             next_baud_upd;
    logic [IDX_W:0]   rx_cnt;
    logic [IDX_W:0]   next_rx_cnt;
    logic [7:0]       rx_single;
    logic [7:0]       next_rx_single;
    logic [7:0]       tx_single;
    logic [7:0]       next_tx_single;
    logic [7:0]       tx_single_q;
    logic [7:0]       next_tx_single_q;
    logic             tx_sel_mbuf;
    logic             next_tx_sel_mbuf;
    logic             next_tx_byte_valid;
    logic [31:0]      rd_reg;
    logic [31:0]      next_rd_reg;
    logic [1:0]       rd_src;
    logic [1:0]       next_rd_src;
    logic             adapt_ok;
    logic             rxbuf_we;
    logic             txbuf_we;
    logic [7:0]       rxbuf_q;
    logic [7:0]       txbuf_q;
    logic [IDX_W-1:0] rx_wr_idx;
    logic             wr_ctrl;
    logic             wr_baud;
    logic             wr_stat;
    logic             wr_tx;

    assign wr_ctrl = reg_wr && (reg_addr == `LCFO_OFF_CTRL);
    assign wr_baud = reg_wr && (reg_addr == `LCFO_OFF_BAUD);
    assign wr_stat = reg_wr && (reg_addr == `LCFO_OFF_STATUS);
    assign wr_tx   = reg_wr && (reg_addr == `LCFO_OFF_TXDATA);

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            LCFO_IDLE: begin
                if (sync_detect) begin
                    next_state = LCFO_SYNC;
                end else if (rx_ev.id_valid) begin
                    next_state = LCFO_DATA;
                end
            end
            LCFO_SYNC: begin
                if (!sync_detect) begin
                    next_state = LCFO_WAIT_ID;
                end
            end
            LCFO_WAIT_ID: begin
                if (rx_ev.id_valid) begin
                    next_state = LCFO_DATA;
                end else if (sync_detect) begin
                    next_state = LCFO_SYNC;
                end
            end
            LCFO_DATA: begin
                if (rx_ev.chk_valid) begin
                    next_state = LCFO_IDLE;
                end else if (sync_detect) begin
                    next_state = LCFO_SYNC;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Control and baud prescaler register
    // ------------------------------------------------------------------
    // Adjust only counts while the sync field is being measured in LIN
    assign adapt_ok = ctrl.lin && ctrl.adapt && ctrl.slave
                      && (state == LCFO_SYNC) && meas.valid;

    always_comb begin
        next_ctrl = ctrl;
        next_baud = baud;
        if (wr_ctrl) begin
            next_ctrl.cks_enh = reg_wdata[`LCFO_CTRL_CKS];
            next_ctrl.mbuf    = reg_wdata[`LCFO_CTRL_MBUF];
            next_ctrl.adapt   = reg_wdata[`LCFO_CTRL_ADAPT];
            next_ctrl.lin     = reg_wdata[`LCFO_CTRL_LIN];
            next_ctrl.slave   = reg_wdata[`LCFO_CTRL_SLAVE];
        end
        if (wr_baud) begin
            next_baud.presc =
                reg_wdata[`LCFO_BAUD_PRESC_MSB:`LCFO_BAUD_PRESC_LSB];
            next_baud.frac  =
                reg_wdata[`LCFO_BAUD_FRAC_MSB:`LCFO_BAUD_FRAC_LSB];
        end
        // Measured rate overrides a same-cycle software write
        if (adapt_ok && (meas.baud != baud)) begin
            next_baud = meas.baud;
        end
        // Without adapt_ok the register keeps the configured rate
    end

    // ------------------------------------------------------------------
    // Checksum and status flags
    // ------------------------------------------------------------------
    always_comb begin
        next_sum      = sum;
        next_last_cks = last_cks;
        next_cks_err  = cks_err;
        next_baud_upd = baud_upd;
        if (wr_stat) begin
            if (reg_wdata[`LCFO_ST_CKS_ERR]) begin
                next_cks_err = 1'b0;
            end
            if (reg_wdata[`LCFO_ST_BAUD_UPD]) begin
                next_baud_upd = 1'b0;
            end
        end
        if (rx_ev.id_valid) begin
            // Enhanced sum covers the protected identifier as well
            next_sum = ctrl.cks_enh ? rx_ev.data : `LCFO_RST_BYTE;
        end else if (rx_ev.data_valid) begin
            next_sum = cks_add(sum, rx_ev.data);
        end else if (tx_byte_valid) begin
            next_sum = cks_add(sum, tx_byte);
        end
        if (rx_ev.chk_valid && (state == LCFO_DATA)) begin
            next_last_cks = rx_ev.data;
            if (cks_add(sum, rx_ev.data) != 8'hff) begin
                next_cks_err = 1'b1;
            end
        end
        if (adapt_ok && (meas.baud != baud)) begin
            next_baud_upd = 1'b1;
        end
    end

    assign tx_cks = ~sum;

    // ------------------------------------------------------------------
    // Data steering between buffers and single registers
    // ------------------------------------------------------------------
    // Same steering in LIN and plain serial mode; ctrl.lin is not read
    assign rx_wr_idx = rx_cnt[IDX_W-1:0];
    assign rxbuf_we  = ctrl.mbuf && rx_ev.data_valid
                       && (rx_cnt < (IDX_W+1)'(DEPTH));
    assign txbuf_we  = reg_wr && is_buf(reg_addr, `LCFO_OFF_TXBUF);

    always_comb begin
        next_rx_cnt      = rx_cnt;
        next_rx_single   = rx_single;
        next_tx_single   = tx_single;
        next_tx_single_q = tx_single_q;
        next_tx_sel_mbuf = tx_sel_mbuf;
        if (rx_ev.id_valid) begin
            next_rx_cnt = '0;
        end else if (rx_ev.data_valid) begin
            if (!ctrl.mbuf) begin
                next_rx_single = rx_ev.data;
            end else if (rx_cnt < (IDX_W+1)'(DEPTH)) begin
                next_rx_cnt = rx_cnt + (IDX_W+1)'(1);
            end
        end
        if (wr_tx) begin
            next_tx_single = reg_wdata[7:0];
        end
        if (tx_req) begin
            next_tx_single_q = tx_single;
            next_tx_sel_mbuf = ctrl.mbuf;
        end
    end

    assign next_tx_byte_valid = tx_req;

    lcfo_buf #(.W(8), .D(DEPTH), .A(IDX_W)) u_rxbuf (
        .clk     (clk),
        .wr_en   (rxbuf_we),
        .wr_addr (rx_wr_idx),
        .wr_data (rx_ev.data),
        .rd_addr (buf_idx(reg_addr - `LCFO_OFF_RXBUF)),
        .rd_data (rxbuf_q)
    );

    lcfo_buf #(.W(8), .D(DEPTH), .A(IDX_W)) u_txbuf (
        .clk     (clk),
        .wr_en   (txbuf_we),
        .wr_addr (buf_idx(reg_addr - `LCFO_OFF_TXBUF)),
        .wr_data (reg_wdata[7:0]),
        .rd_addr (tx_idx),
        .rd_data (txbuf_q)
    );

    assign tx_byte = tx_sel_mbuf ? txbuf_q : tx_single_q;

    // ------------------------------------------------------------------
    // Register read path, data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        next_rd_reg = 32'h00000000;
        next_rd_src = 2'h0;
        if (reg_rd) begin
            if (reg_addr == `LCFO_OFF_CTRL) begin
                next_rd_reg[`LCFO_CTRL_CKS]   = ctrl.cks_enh;
                next_rd_reg[`LCFO_CTRL_MBUF]  = ctrl.mbuf;
                next_rd_reg[`LCFO_CTRL_ADAPT] = ctrl.adapt;
                next_rd_reg[`LCFO_CTRL_LIN]   = ctrl.lin;
                next_rd_reg[`LCFO_CTRL_SLAVE] = ctrl.slave;
            end else if (reg_addr == `LCFO_OFF_BAUD) begin
                next_rd_reg = {5'h00, baud.frac, baud.presc};
            end else if (reg_addr == `LCFO_OFF_STATUS) begin
                next_rd_reg[`LCFO_ST_CKS_ERR]  = cks_err;
                next_rd_reg[`LCFO_ST_BAUD_UPD] = baud_upd;
                next_rd_reg[`LCFO_ST_MEAS]     = (state == LCFO_SYNC);
                next_rd_reg[`LCFO_ST_CNT_MSB:`LCFO_ST_CNT_LSB] =
                    4'(rx_cnt);
            end else if (reg_addr == `LCFO_OFF_RXDATA) begin
                next_rd_reg[7:0] = rx_single;
            end else if (reg_addr == `LCFO_OFF_TXDATA) begin
                next_rd_reg[7:0] = tx_single;
            end else if (reg_addr == `LCFO_OFF_CKSUM) begin
                next_rd_reg[15:0] = {last_cks, ~sum};
            end else if (is_buf(reg_addr, `LCFO_OFF_RXBUF)) begin
                next_rd_src = 2'h1;
            end
        end
    end

    assign reg_rdata = (rd_src == 2'h1) ? {24'h000000, rxbuf_q} : rd_reg;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state         <= LCFO_IDLE;
            ctrl          <= '0;
            baud.presc    <= `LCFO_RST_PRESC;
            baud.frac     <= `LCFO_RST_FRAC;
            sum           <= `LCFO_RST_BYTE;
            last_cks      <= `LCFO_RST_BYTE;
            cks_err       <= 1'b0;
            baud_upd      <= 1'b0;
            rx_cnt        <= '0;
            rx_single     <= `LCFO_RST_BYTE;
            tx_single     <= `LCFO_RST_BYTE;
            tx_single_q   <= `LCFO_RST_BYTE;
            tx_sel_mbuf   <= 1'b0;
            tx_byte_valid <= 1'b0;
            rd_reg        <= 32'h00000000;
            rd_src        <= 2'h0;
        end else begin
            state         <= next_state;
            ctrl          <= next_ctrl;
            baud          <= next_baud;
            sum           <= next_sum;
            last_cks      <= next_last_cks;
            cks_err       <= next_cks_err;
            baud_upd      <= next_baud_upd;
            rx_cnt        <= next_rx_cnt;
            rx_single     <= next_rx_single;
            tx_single     <= next_tx_single;
            tx_single_q   <= next_tx_single_q;
            tx_sel_mbuf   <= next_tx_sel_mbuf;
            tx_byte_valid <= next_tx_byte_valid;
            rd_reg        <= next_rd_reg;
            rd_src        <= next_rd_src;
        end
    end

endmodule // lcfo_core

// file: verif/lcfo_core_assertions.sv
// Port-level concurrent checks of the frame options core
`timescale 1ns/10ps
`include "lcfo_map.svh"
module lcfo_core_assertions import lcfo_pkg::*; #(
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [31:0]      reg_rdata,
    input  wire logic             sync_detect,
    input  wire lcfo_meas_t       meas,
    input  wire lcfo_rx_t         rx_ev,
    input  wire logic             tx_req,
    input  wire logic [IDX_W-1:0] tx_idx,
    input  wire logic [7:0]       tx_byte,
    input  wire logic             tx_byte_valid,
    input  wire logic [7:0]       tx_cks,
    input  wire lcfo_baud_t       baud,
    input  wire lcfo_ctrl_t       ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    logic       baud_wr;
    logic [4:0] ctrl_in;
    logic [7:0] seed;
    assign baud_wr = reg_wr && reg_addr == `LCFO_OFF_BAUD;
    assign ctrl_in = {reg_wdata[11:9], reg_wdata[6:5]};
    assign seed    = ctrl.cks_enh ? rx_ev.data : 8'h00;

    // Two cycles of sync field with a differing measurement inside it
    sequence s_sync_meas;
        sync_detect ##1 sync_detect && meas.valid && ctrl.lin && ctrl.adapt
            && ctrl.slave && meas.baud != baud;
    endsequence

    a_adapt_load: assert property (
        s_sync_meas |=> baud == $past(meas.baud))
        else $error("baud not loaded from measurement");
    a_adapt_off: assert property (
        !ctrl.adapt && !baud_wr |=> $stable(baud))
        else $error("baud moved with adjust disabled");
    a_lin_only: assert property (
        !ctrl.lin && !baud_wr |=> $stable(baud))
        else $error("baud moved outside lin mode");
    a_slave_only: assert property (
        !ctrl.slave && !baud_wr |=> $stable(baud))
        else $error("baud moved in master role");
    a_meas_gate: assert property (
        !meas.valid && !baud_wr |=> $stable(baud))
        else $error("baud moved without measurement");
    a_baud_sw: assert property (
        baud_wr && !meas.valid |=> baud == $past(reg_wdata[26:0]))
        else $error("baud write not taken whole");
    a_ctrl_wr: assert property (
        reg_wr && reg_addr == `LCFO_OFF_CTRL |=> ctrl == $past(ctrl_in))
        else $error("control write not taken");
    a_tx_pulse: assert property (
        tx_byte_valid == $past(tx_req))
        else $error("transmit byte pulse out of step");
    a_cks_seed: assert property (
        rx_ev.id_valid |=> tx_cks == ~$past(seed))
        else $error("checksum seed wrong for kind");
endmodule // lcfo_core_assertions

bind lcfo_core lcfo_core_assertions #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_detect(sync_detect), .meas(meas), .rx_ev(rx_ev), .tx_req(tx_req),
    .tx_idx(tx_idx), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_cks(tx_cks), .baud(baud), .ctrl(ctrl)
);

// file: verif/lcfo_lin_node.sv
// Behavioural model of the other nodes on the serial bus
`timescale 1ns/10ps
module lcfo_lin_node import lcfo_pkg::*; (
    input  wire logic       clk,
    output      logic       sync_detect,
    output      lcfo_meas_t meas,
    output      lcfo_rx_t   rx_ev
);
    initial begin
        sync_detect = 1'b0;
        meas        = '0;
        rx_ev       = '0;
    end

    // One event, then an idle cycle; stale data is inverted, not held
    task automatic put_ev(input logic [2:0] kind, input logic [7:0] b);
        rx_ev <= {kind, b};
        @(posedge clk);
        rx_ev <= {3'b000, ~b};
        @(posedge clk);
    endtask

    // Measurement lands one cycle into the sync field
    task automatic sync_field(input lcfo_baud_t b, input logic in_sync);
        sync_detect <= in_sync;
        @(posedge clk);
        meas <= {1'b1, b};
        @(posedge clk);
        meas        <= {1'b0, ~b};
        sync_detect <= 1'b0;
        @(posedge clk);
    endtask
endmodule // lcfo_lin_node

// file: verif/lcfo_core_tb.sv
// Self-checking bench of the frame options core
`timescale 1ns/10ps
`include "lcfo_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module lcfo_core_tb import lcfo_pkg::*;;
    logic        clk, nrst, reg_wr, reg_rd, sync_detect, tx_req, tx_byte_valid;
    logic [7:0]  reg_addr, tx_byte, tx_cks, sum;
    logic [31:0] reg_wdata, reg_rdata, rd_val, cfg;
    logic [2:0]  tx_idx;
    logic [3:0]  adapt_tab [5];
    lcfo_meas_t  meas;
    lcfo_rx_t    rx_ev;
    lcfo_baud_t  baud, nb, exp_b;
    lcfo_ctrl_t  ctrl;
    int          bad_count, n_tests;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    lcfo_core #(.DEPTH(8), .IDX_W(3)) u_dut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_detect(sync_detect), .meas(meas), .rx_ev(rx_ev),
        .tx_req(tx_req), .tx_idx(tx_idx), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_cks(tx_cks), .baud(baud),
        .ctrl(ctrl));
    lcfo_lin_node u_node (.clk(clk), .sync_detect(sync_detect), .meas(meas),
        .rx_ev(rx_ev));

    // ----------------------------------------------------------------
    // Bus and transmit tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        // Read data stands only in the cycle after the strobe
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic tx(input logic [2:0] i, input logic [7:0] e);
        tx_idx <= i;
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        @(posedge clk);
        `CHK("tx_byte_valid", 1'b1, tx_byte_valid)
        `CHK("tx_byte", e, tx_byte)
    endtask
    // Ones-complement style add: the carry wraps into bit 0
    function automatic logic [7:0] add_wrap(input logic [7:0] s,
                                            input logic [7:0] b);
        logic [8:0] t;
        t = s + b;
        return t[7:0] + t[8];
    endfunction
    task print_verdict;
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0;
        reg_rd = 1'b0; tx_req = 1'b0; tx_idx = 3'h0;
        bad_count = 0; n_tests = 0;
        adapt_tab = '{4'hf, 4'h7, 4'hb, 4'hd, 4'he};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(`LCFO_OFF_CTRL, rd_val);
        `CHK("ctrl reset", 32'h0, rd_val)
        rd(`LCFO_OFF_BAUD, rd_val);
        `CHK("baud reset", 32'h0, rd_val)
        // Transmit source in both buffer modes, lin and plain serial
        for (int k = 0; k < 4; k++) begin
            cfg = 32'h0;
            cfg[`LCFO_CTRL_MBUF] = k[1];
            cfg[`LCFO_CTRL_LIN]  = k[0];
            wr(`LCFO_OFF_CTRL, cfg);
            wr(`LCFO_OFF_TXBUF + 8'h0c, {24'h0, 8'ha0 + 8'(k)});
            wr(`LCFO_OFF_TXDATA, {24'h0, 8'h50 + 8'(k)});
            tx(3'h3, k[1] ? 8'ha0 + 8'(k) : 8'h50 + 8'(k));
        end
        // Frames with both checksum kinds; bad checksum in buffer mode
        for (int k = 0; k < 4; k++) begin
            cfg = 32'h0;
            cfg[`LCFO_CTRL_CKS]  = k[0];
            cfg[`LCFO_CTRL_MBUF] = k[1];
            cfg[`LCFO_CTRL_LIN]  = 1'b1;
            wr(`LCFO_OFF_CTRL, cfg);
            sum = k[0] ? 8'hc1 : 8'h00;
            u_node.put_ev(3'b100, 8'hc1);
            sum = add_wrap(sum, 8'hf0);
            u_node.put_ev(3'b010, 8'hf0);
            sum = add_wrap(sum, 8'h35 + 8'(k));
            u_node.put_ev(3'b010, 8'h35 + 8'(k));
            `CHK("tx_cks", ~sum, tx_cks)
            u_node.put_ev(3'b001, ~sum ^ {7'h0, k[1]});
            rd(`LCFO_OFF_CKSUM, rd_val);
            `CHK("cksum reg", {16'h0, ~sum ^ {7'h0, k[1]}, ~sum}, rd_val)
            rd(`LCFO_OFF_STATUS, rd_val);
            `CHK("cks_err", k[1], rd_val[`LCFO_ST_CKS_ERR])
            `CHK("rx count", k[1] ? 4'h2 : 4'h0, rd_val[11:8])
            wr(`LCFO_OFF_STATUS, 32'h1);
            if (k[1]) begin
                rd(`LCFO_OFF_RXBUF, rd_val);
                `CHK("rx slot 0", 32'hf0, rd_val)
                rd(`LCFO_OFF_RXBUF + 8'h04, rd_val);
                `CHK("rx slot 1", 32'h35 + k, rd_val)
            end else begin
                rd(`LCFO_OFF_RXDATA, rd_val);
                `CHK("rx single", 32'h35 + k, rd_val)
            end
        end
        // Rate adaptation: only lin, adjust, slave and sync together load
        for (int k = 0; k < 5; k++) begin
            cfg = 32'h0;
            cfg[`LCFO_CTRL_LIN]   = adapt_tab[k][3];
            cfg[`LCFO_CTRL_ADAPT] = adapt_tab[k][2];
            cfg[`LCFO_CTRL_SLAVE] = adapt_tab[k][1];
            wr(`LCFO_OFF_BAUD, {5'h0, 3'h2, 24'h000101});
            wr(`LCFO_OFF_CTRL, cfg);
            nb = {3'h5, 24'h00a0b0 + 24'(k)};
            u_node.sync_field(nb, adapt_tab[k][0]);
            exp_b = (k == 0) ? nb : {3'h2, 24'h000101};
            rd(`LCFO_OFF_BAUD, rd_val);
            `CHK("baud reg", {5'h0, exp_b}, rd_val)
            `CHK("baud port", exp_b, baud)
            rd(`LCFO_OFF_STATUS, rd_val);
            `CHK("baud_upd", k == 0, rd_val[`LCFO_ST_BAUD_UPD])
            wr(`LCFO_OFF_STATUS, 32'h2);
        end
        print_verdict();
    end
endmodule // lcfo_core_tb
